// *** core/aacr_pkg.sv ***
// Overview of operation
// - offset 0 is a read-only 8-bit identification byte holding a fixed code.
// - clip threshold is 20 bits; power control bits 7:2 give its top six.
// - sleep bit set disables the power stage, low-voltage blocks stay on standby.
// - shutdown control low powers down digital and power-stage domains.
// - digital control bit 7 set bypasses the high-pass filter, clear keeps it.
// - digital control bit 6 is reserved and read-only; host leaves it alone.
// - boost field bits 5:4 add 0, 6, 12 or 18 dB of digital gain.
// - speed select low means single-speed rates, high means double-speed rates.
// - format codes 0-3 right-justified 24/20/18/16, 4 I2S, 5 left-justified.
// - volume configuration bit 7 enables volume fading when set.
// - volume configuration bits 6:2 are reserved and read-only.
// - right-mute bit mutes right channel; its outputs go to 50/50 duty.
// - left-mute bit mutes left channel the same soft way.
// - volume code 0xff is +24 dB, 0xcf is 0 dB, 0x07 is -100 dB.
// - any volume code below 0x07 mutes that channel.
// - left volume sits at offset 4, right at offset 5, same encoding.
// - a write is device address, register offset byte, data byte; each acked.
`default_nettype none
package aacr_pkg;
  localparam logic [7:0] ADDR_PART_ID = 8'h00;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h01;
  localparam logic [7:0] ADDR_DIGITAL_CTRL = 8'h02;
  localparam logic [7:0] ADDR_VOLUME_CFG = 8'h03;
  localparam logic [7:0] ADDR_LEFT_VOL = 8'h04;
  localparam logic [7:0] ADDR_RIGHT_VOL = 8'h05;

  localparam logic [7:0] RST_POWER_CTRL = 8'hfd;
  localparam logic [7:0] RST_DIGITAL_CTRL = 8'h14;
  localparam logic [7:0] RST_VOLUME_CFG = 8'h80;
  localparam logic [7:0] RST_VOLUME = 8'hcf;

  // writable bits per register; reserved read-only bits stay at their reset value
  localparam logic [7:0] WMASK_DIGITAL_CTRL = 8'hbf;
  localparam logic [7:0] WMASK_VOLUME_CFG = 8'h83;

  localparam int POS_CLIP_HI = 2;
  localparam int POS_SLEEP = 1;
  localparam int POS_SHUTDOWN_N = 0;
  localparam int POS_HIGHPASS_SKIP = 7;
  localparam int POS_BOOST = 4;
  localparam int POS_RATE_SPEED = 3;
  localparam int POS_FORMAT = 0;
  localparam int POS_FADE = 7;
  localparam int POS_MUTE_R = 1;
  localparam int POS_MUTE_L = 0;

  // lower clip threshold bits live in registers outside this bank; held at their defaults
  localparam logic [13:0] CLIP_LOWER_DEFAULT = 14'h3fff;

  localparam logic [7:0] VOL_MUTE_BELOW = 8'h07;
  localparam logic [8:0] VOL_ZERO_DB_CODE = 9'h0cf;
  localparam logic [4:0] BOOST_STEP_DB = 5'h06;

  // arbitrary identification value, chosen freely
  localparam logic [7:0] PART_CODE_DEFAULT = 8'h5a;
  // control port device address with the select strap low; strap sets bit 0
  localparam logic [6:0] DEV_ADDR_BASE = 7'h6c;

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] digital;
    logic [7:0] volcfg;
    logic [7:0] left;
    logic [7:0] right;
  } aacr_regs_s;

  typedef struct packed {
    logic mute;
    logic signed [8:0] gain_half_db;
  } aacr_chan_s;
endpackage
`default_nettype wire

// *** core/aacr_sync.sv ***
`default_nettype none
module aacr_sync
  import aacr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  for (genvar g = 0; g < WIDTH; g++) begin : gen_bit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        meta[g] <= 1'b1;
        o_sync[g] <= 1'b1;
      end else if (i_ce) begin
        meta[g] <= i_async[g];
        o_sync[g] <= meta[g];
      end
    end
  end
endmodule
`default_nettype wire

// *** core/aacr_vol.sv ***
`default_nettype none
module aacr_vol
  import aacr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_code,
  input wire logic i_mute_bit,
  output aacr_chan_s o_chan
);
  logic signed [8:0] next_gain;

  // half-dB units: 0xff gives +48 (+24 dB), 0x07 gives -200 (-100 dB)
  always_comb begin
    next_gain = $signed({1'b0, i_code}) - $signed(VOL_ZERO_DB_CODE);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chan <= '0;
    end else if (i_ce) begin
      o_chan.mute <= i_mute_bit || (i_code < VOL_MUTE_BELOW);
      o_chan.gain_half_db <= next_gain;
    end
  end
endmodule
`default_nettype wire

// *** core/aacr_top.sv ***
`default_nettype none
module aacr_top
  import aacr_pkg::*;
#(
  parameter logic [7:0] PART_CODE = PART_CODE_DEFAULT
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_SCL,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  input wire logic I_ADDR_SEL,
  output logic [19:0] O_CLIP_THRESHOLD_LEVEL,
  output logic O_AMP_SLEEP,
  output logic O_AMP_SHUTDOWN_N,
  output logic O_POWER_STAGE_EN,
  output logic O_DIGITAL_EN,
  output logic O_HIGHPASS_SKIP,
  output logic [4:0] O_BOOST_DB,
  output logic O_RATE_SPEED_SELECT,
  output logic [2:0] O_INPUT_FORMAT,
  output logic O_FADE_EN,
  output logic O_MUTE_L,
  output logic O_MUTE_R,
  output logic signed [8:0] O_GAIN_L,
  output logic signed [8:0] O_GAIN_R
);
  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_ADDR = 10'b00_0000_0010,
    ST_ADDR_ACK = 10'b00_0000_0100,
    ST_INDEX = 10'b00_0000_1000,
    ST_INDEX_ACK = 10'b00_0001_0000,
    ST_WDATA = 10'b00_0010_0000,
    ST_WDATA_ACK = 10'b00_0100_0000,
    ST_RDATA = 10'b00_1000_0000,
    ST_RDATA_ACK = 10'b01_0000_0000,
    ST_RDATA_LOAD = 10'b10_0000_0000
  } aacr_state_e;

  aacr_state_e state;
  aacr_state_e next_state;
  logic [2:0] sync_q;
  logic scl_q;
  logic sda_q;
  logic addr_sel_q;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic rw;
  logic ack_on;
  logic [7:0] index;
  logic [7:0] rd_value;
  logic [7:0] rx_byte;
  logic [6:0] dev_addr;
  logic rx_state;
  logic ack_state;
  logic byte_done;
  logic addr_hit;
  logic ack_end;
  logic rd_load;
  logic rd_acked;
  logic wr_stb;
  logic sda_drive;
  aacr_regs_s regs;
  aacr_chan_s chan_l;
  aacr_chan_s chan_r;

  // scl, sda and the address strap all come from pins
  aacr_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_async({I_ADDR_SEL, I_SDA_IN, I_SCL}),
    .o_sync(sync_q)
  );

  assign scl_q = sync_q[0];
  assign sda_q = sync_q[1];
  assign addr_sel_q = sync_q[2];

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (I_CE) begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_d;
  assign scl_fall = !scl_q && scl_d;
  assign start_cond = scl_q && scl_d && sda_d && !sda_q;
  assign stop_cond = scl_q && scl_d && !sda_d && sda_q;

  assign dev_addr = {DEV_ADDR_BASE[6:1], addr_sel_q};
  assign rx_byte = {shift[6:0], sda_q};
  assign rx_state = (state == ST_ADDR) || (state == ST_INDEX) || (state == ST_WDATA);
  assign ack_state = (state == ST_ADDR_ACK) || (state == ST_INDEX_ACK) ||
                     (state == ST_WDATA_ACK);
  assign byte_done = scl_rise && rx_state && (bit_cnt == 3'h7);
  assign addr_hit = rx_byte[7:1] == dev_addr;
  // the ack bit ends on the scl fall after it was driven
  assign ack_end = scl_fall && ack_state && ack_on;
  assign rd_load = (ack_end && (state == ST_ADDR_ACK) && rw) ||
                   (scl_fall && (state == ST_RDATA_LOAD));
  assign rd_acked = scl_rise && (state == ST_RDATA_ACK) && !sda_q;
  assign wr_stb = byte_done && (state == ST_WDATA) && !start_cond && !stop_cond;

  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = ST_ADDR;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_ADDR: begin
          if (byte_done) begin
            next_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (ack_end) begin
            next_state = rw ? ST_RDATA : ST_INDEX;
          end
        end
        ST_INDEX: begin
          if (byte_done) begin
            next_state = ST_INDEX_ACK;
          end
        end
        ST_INDEX_ACK: begin
          if (ack_end) begin
            next_state = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            next_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          if (ack_end) begin
            next_state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise && (bit_cnt == 3'h7)) begin
            next_state = ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_state = sda_q ? ST_IDLE : ST_RDATA_LOAD;
          end
        end
        ST_RDATA_LOAD: begin
          if (scl_fall) begin
            next_state = ST_RDATA;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= ST_IDLE;
    end else if (I_CE) begin
      state <= next_state;
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      rw <= 1'b0;
    end else if (I_CE) begin
      if (start_cond || stop_cond) begin
        bit_cnt <= 3'h0;
      end else if (scl_rise && (rx_state || state == ST_RDATA)) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift <= rx_byte;
        if (byte_done && (state == ST_ADDR)) begin
          rw <= sda_q;
        end
      end else if (ack_end || rd_load) begin
        bit_cnt <= 3'h0;
      end
    end
  end

  // open-drain data pin: only ever pulled low, released otherwise
  always_comb begin
    sda_drive = O_SDA_OE;
    if (start_cond || stop_cond) begin
      sda_drive = 1'b0;
    end else if (rd_load) begin
      sda_drive = !rd_value[7];
    end else if (scl_fall && (state == ST_RDATA) && (bit_cnt != 3'h0)) begin
      sda_drive = !tx[7];
    end else if (scl_fall && (state == ST_RDATA) && (bit_cnt == 3'h0)) begin
      sda_drive = O_SDA_OE;
    end else if (ack_end) begin
      sda_drive = 1'b0;
    end else if (scl_fall && ack_state) begin
      sda_drive = 1'b1;
    end else if (scl_fall && (state == ST_RDATA_ACK)) begin
      sda_drive = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SDA_OE <= 1'b0;
      O_SDA_OUT <= 1'b0;
      ack_on <= 1'b0;
      tx <= 8'h00;
    end else if (I_CE) begin
      O_SDA_OE <= sda_drive;
      O_SDA_OUT <= 1'b0;
      if (start_cond || stop_cond || ack_end) begin
        ack_on <= 1'b0;
      end else if (scl_fall && ack_state) begin
        ack_on <= 1'b1;
      end
      if (rd_load) begin
        tx <= {rd_value[6:0], 1'b0};
      end else if (scl_fall && (state == ST_RDATA) && (bit_cnt != 3'h0)) begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // register pointer, auto-incremented after each written byte and each acked read byte
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      index <= 8'h00;
    end else if (I_CE) begin
      if (byte_done && (state == ST_INDEX) && !start_cond && !stop_cond) begin
        index <= rx_byte;
      end else if (wr_stb || rd_acked) begin
        index <= index + 8'h01;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (index)
      ADDR_PART_ID: rd_value = PART_CODE;
      ADDR_POWER_CTRL: rd_value = regs.power;
      ADDR_DIGITAL_CTRL: rd_value = regs.digital;
      ADDR_VOLUME_CFG: rd_value = regs.volcfg;
      ADDR_LEFT_VOL: rd_value = regs.left;
      ADDR_RIGHT_VOL: rd_value = regs.right;
      default: rd_value = 8'h00;
    endcase
  end

  // writes to offset 0 and to unmapped offsets are acked but dropped
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      regs.power <= RST_POWER_CTRL;
      regs.digital <= RST_DIGITAL_CTRL;
      regs.volcfg <= RST_VOLUME_CFG;
      regs.left <= RST_VOLUME;
      regs.right <= RST_VOLUME;
    end else if (I_CE && wr_stb) begin
      case (index)
        ADDR_POWER_CTRL: regs.power <= rx_byte;
        ADDR_DIGITAL_CTRL: begin
          regs.digital <= (rx_byte & WMASK_DIGITAL_CTRL) |
                          (RST_DIGITAL_CTRL & ~WMASK_DIGITAL_CTRL);
        end
        ADDR_VOLUME_CFG: begin
          regs.volcfg <= (rx_byte & WMASK_VOLUME_CFG) |
                         (RST_VOLUME_CFG & ~WMASK_VOLUME_CFG);
        end
        ADDR_LEFT_VOL: regs.left <= rx_byte;
        ADDR_RIGHT_VOL: regs.right <= rx_byte;
        default: regs.power <= regs.power;
      endcase
    end
  end

  aacr_vol u_vol_l (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_code(regs.left),
    .i_mute_bit(regs.volcfg[POS_MUTE_L]),
    .o_chan(chan_l)
  );

  aacr_vol u_vol_r (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_code(regs.right),
    .i_mute_bit(regs.volcfg[POS_MUTE_R]),
    .o_chan(chan_r)
  );

  assign O_MUTE_L = chan_l.mute;
  assign O_MUTE_R = chan_r.mute;
  assign O_GAIN_L = chan_l.gain_half_db;
  assign O_GAIN_R = chan_r.gain_half_db;

  // control outputs, registered so they move one cycle after the write lands
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CLIP_THRESHOLD_LEVEL <= {RST_POWER_CTRL[7:POS_CLIP_HI], CLIP_LOWER_DEFAULT};
      O_AMP_SLEEP <= RST_POWER_CTRL[POS_SLEEP];
      O_AMP_SHUTDOWN_N <= RST_POWER_CTRL[POS_SHUTDOWN_N];
      O_POWER_STAGE_EN <= RST_POWER_CTRL[POS_SHUTDOWN_N] && !RST_POWER_CTRL[POS_SLEEP];
      O_DIGITAL_EN <= RST_POWER_CTRL[POS_SHUTDOWN_N];
      O_HIGHPASS_SKIP <= RST_DIGITAL_CTRL[POS_HIGHPASS_SKIP];
      O_BOOST_DB <= BOOST_STEP_DB * {3'h0, RST_DIGITAL_CTRL[POS_BOOST+:2]};
      O_RATE_SPEED_SELECT <= RST_DIGITAL_CTRL[POS_RATE_SPEED];
      O_INPUT_FORMAT <= RST_DIGITAL_CTRL[POS_FORMAT+:3];
      O_FADE_EN <= RST_VOLUME_CFG[POS_FADE];
    end else if (I_CE) begin
      O_CLIP_THRESHOLD_LEVEL <= {regs.power[7:POS_CLIP_HI], CLIP_LOWER_DEFAULT};
      O_AMP_SLEEP <= regs.power[POS_SLEEP];
      O_AMP_SHUTDOWN_N <= regs.power[POS_SHUTDOWN_N];
      // sleep keeps the digital domain on standby, only the power stage drops
      O_POWER_STAGE_EN <= regs.power[POS_SHUTDOWN_N] && !regs.power[POS_SLEEP];
      O_DIGITAL_EN <= regs.power[POS_SHUTDOWN_N];
      O_HIGHPASS_SKIP <= regs.digital[POS_HIGHPASS_SKIP];
      O_BOOST_DB <= BOOST_STEP_DB * {3'h0, regs.digital[POS_BOOST+:2]};
      O_RATE_SPEED_SELECT <= regs.digital[POS_RATE_SPEED];
      // reserved codes above 5 are passed through unchanged; the host must not use them
      O_INPUT_FORMAT <= regs.digital[POS_FORMAT+:3];
      O_FADE_EN <= regs.volcfg[POS_FADE];
    end
  end
endmodule
`default_nettype wire

// *** dv/aacr_properties.sv ***
`default_nettype none
module aacr_properties (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_SCL,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic [19:0] O_CLIP_THRESHOLD_LEVEL,
  input wire logic O_AMP_SLEEP,
  input wire logic O_AMP_SHUTDOWN_N,
  input wire logic O_POWER_STAGE_EN,
  input wire logic O_DIGITAL_EN,
  input wire logic [4:0] O_BOOST_DB,
  input wire logic [2:0] O_INPUT_FORMAT,
  input wire logic O_MUTE_L,
  input wire logic O_MUTE_R,
  input wire logic signed [8:0] O_GAIN_L,
  input wire logic signed [8:0] O_GAIN_R
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  a_stage_en: assert property (O_POWER_STAGE_EN == (O_AMP_SHUTDOWN_N && !O_AMP_SLEEP))
    else $error("power stage enable wrong");
  a_digital_en: assert property (O_DIGITAL_EN == O_AMP_SHUTDOWN_N)
    else $error("digital enable wrong");
  a_boost_step: assert property (O_BOOST_DB inside {5'h00, 5'h06, 5'h0c, 5'h12})
    else $error("boost not a 6 dB step");
  a_clip_lower: assert property (O_CLIP_THRESHOLD_LEVEL[13:0] == 14'h3fff)
    else $error("clip lower bits moved");
  a_gain_range: assert property (O_GAIN_L >= -207 && O_GAIN_L <= 48)
    else $error("left gain out of range");
  a_mute_low_l: assert property (O_GAIN_L < -200 |-> O_MUTE_L)
    else $error("left low code not muted");
  a_mute_low_r: assert property (O_GAIN_R < -200 |-> O_MUTE_R)
    else $error("right low code not muted");
  a_sda_open: assert property (O_SDA_OE |-> !O_SDA_OUT)
    else $error("data pin driven high");
  a_ack_timing: assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2))
    else $error("data pin moved outside clock low");
  a_cfg_on_byte: assert property (
    $changed({O_INPUT_FORMAT, O_BOOST_DB, O_CLIP_THRESHOLD_LEVEL}) |-> I_SCL && $past(I_SCL))
    else $error("config changed off a data bit");
  a_gain_on_byte: assert property (
    $changed({O_GAIN_L, O_GAIN_R, O_MUTE_L, O_MUTE_R}) |-> I_SCL)
    else $error("volume changed off a data bit");
  c_sleep: cover property (O_AMP_SLEEP && O_AMP_SHUTDOWN_N);
  c_mute_code: cover property (O_MUTE_L && O_GAIN_L < -200);
  c_ack: cover property ($rose(O_SDA_OE));
endmodule

bind aacr_top aacr_properties u_props (
  .I_CLK, .I_ARST_N, .I_SCL, .O_SDA_OUT, .O_SDA_OE, .O_CLIP_THRESHOLD_LEVEL, .O_AMP_SLEEP,
  .O_AMP_SHUTDOWN_N, .O_POWER_STAGE_EN, .O_DIGITAL_EN, .O_BOOST_DB, .O_INPUT_FORMAT,
  .O_MUTE_L, .O_MUTE_R, .O_GAIN_L, .O_GAIN_R
);
`default_nettype wire

// *** dv/aacr_host.sv ***
`default_nettype none
module aacr_host
  import aacr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // data moves only mid-low; sampling on the falling edge avoids racing the device
  task automatic bitx(input logic b, output logic r);
    o_scl <= 1'b0;
    hold(4);
    o_sda <= b;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    @(negedge i_clk);
    r = i_sda;
    hold(4);
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic first, input logic last);
    o_scl <= 1'b0;
    hold(4);
    o_sda <= first;
    hold(4);
    o_scl <= 1'b1;
    hold(8);
    o_sda <= last;
    hold(8);
  endtask
  task automatic bytex(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(ab, r);
    ok = !r;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d, input logic [6:0] a,
                    output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    cond(1'b1, 1'b0);
    bytex({a, 1'b0}, 1'b1, q, k1);
    bytex(off, 1'b1, q, k2);
    bytex(d, 1'b1, q, k3);
    cond(1'b0, 1'b1);
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3, k4;
    cond(1'b1, 1'b0);
    bytex({DEV_ADDR_BASE, 1'b0}, 1'b1, x, k1);
    bytex(off, 1'b1, x, k2);
    cond(1'b1, 1'b0);
    bytex({DEV_ADDR_BASE, 1'b1}, 1'b1, x, k3);
    bytex(8'hff, 1'b1, q, k4);
    cond(1'b0, 1'b1);
    ok = k1 & k2 & k3;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_audio_amp_control_registers.sv ***
`default_nettype none
module tb_audio_amp_control_registers
  import aacr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary identification value
  localparam logic [7:0] PART = 8'h3c;
  logic clk, arst_n, ce, scl, host_sda, addr_sel, sda_out, sda_oe;
  logic sleep, sdn, pse, den, hps, spd, fade, mute_l, mute_r;
  logic [19:0] clip;
  logic [4:0] boost;
  logic [2:0] fmt;
  logic signed [8:0] gain_l, gain_r;
  wire sda = sda_oe ? sda_out : host_sda;
  int fails = 0;
  int n_compared = 0;
  logic [7:0] rv [6] = '{PART, 8'hfd, 8'h14, 8'h80, 8'hcf, 8'hcf};
  logic [7:0] pw [4] = '{8'h02, 8'ha9, 8'h03, 8'hfc};
  logic [7:0] vc [4] = '{8'h7f, 8'h82, 8'h81, 8'h00};
  logic [7:0] vt [6] = '{8'hff, 8'hcf, 8'h07, 8'h06, 8'h00, 8'h80};
  aacr_top #(.PART_CODE(PART)) u_dut (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_SCL(scl), .I_SDA_IN(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_ADDR_SEL(addr_sel),
    .O_CLIP_THRESHOLD_LEVEL(clip), .O_AMP_SLEEP(sleep), .O_AMP_SHUTDOWN_N(sdn),
    .O_POWER_STAGE_EN(pse), .O_DIGITAL_EN(den), .O_HIGHPASS_SKIP(hps), .O_BOOST_DB(boost),
    .O_RATE_SPEED_SELECT(spd), .O_INPUT_FORMAT(fmt), .O_FADE_EN(fade), .O_MUTE_L(mute_l),
    .O_MUTE_R(mute_r), .O_GAIN_L(gain_l), .O_GAIN_R(gain_r)
  );
  aacr_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] off, input logic [7:0] d);
    logic ok;
    u_host.wr(off, d, DEV_ADDR_BASE, ok);
    chk("write ack", ok, 1'b1);
  endtask
  task automatic rreg(input logic [7:0] off, input logic [7:0] exp, input string nm);
    logic [7:0] q;
    logic ok;
    u_host.rd(off, q, ok);
    chk("read ack", ok, 1'b1);
    chk(nm, q, exp);
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    logic [7:0] d, c;
    logic ok;
    logic signed [8:0] g;
    arst_n = 1'b0;
    ce = 1'b1;
    addr_sel = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("clip", clip, 20'hfffff);
    chk("power", {sleep, sdn, pse, den}, 4'h7);
    chk("dig", {hps, boost, spd, fmt}, {1'b0, 5'h06, 1'b0, 3'h4});
    chk("fade", fade, 1'b1);
    chk("volcfg", {mute_l, mute_r, gain_l, gain_r}, 20'h00000);
    foreach (rv[i]) rreg(8'(i), rv[i], "reset value");
    $display("test reset done");
    foreach (pw[i]) begin
      d = pw[i];
      wreg(ADDR_POWER_CTRL, d);
      rreg(ADDR_POWER_CTRL, d, "power rb");
      chk("clip", clip, {d[7:2], 14'h3fff});
      chk("sleep", {sleep, pse}, {d[1], d[0] & ~d[1]});
      chk("shutdown", {sdn, den}, {d[0], d[0]});
    end
    $display("test power done");
    for (int k = 0; k < 6; k++) begin
      d = {k[0], 1'b1, k[1:0], k[1], k[2:0]};
      wreg(ADDR_DIGITAL_CTRL, d);
      rreg(ADDR_DIGITAL_CTRL, d & 8'hbf, "digital rb");
      chk("hpf", hps, d[7]);
      chk("boost", boost, 5'(6 * d[5:4]));
      chk("speed", spd, d[3]);
      chk("format", fmt, d[2:0]);
    end
    $display("test digital done");
    foreach (vc[i]) begin
      d = vc[i];
      wreg(ADDR_VOLUME_CFG, d);
      rreg(ADDR_VOLUME_CFG, d & 8'h83, "volcfg rb");
      chk("fade", fade, d[7]);
      chk("mute_r", mute_r, d[1]);
      chk("mute_l", mute_l, d[0]);
    end
    $display("test volcfg done");
    foreach (vt[i]) begin
      c = vt[i];
      wreg(ADDR_LEFT_VOL, c);
      wreg(ADDR_RIGHT_VOL, ~c);
      rreg(ADDR_LEFT_VOL, c, "left rb");
      rreg(ADDR_RIGHT_VOL, ~c, "right rb");
      g = $signed({1'b0, c}) - 9'sd207;
      chk("gain_l", gain_l, g);
      chk("mute_l", mute_l, c < 8'h07);
      g = $signed({1'b0, ~c}) - 9'sd207;
      chk("gain_r", gain_r, g);
      chk("mute_r", mute_r, ~c < 8'h07);
    end
    $display("test volume done");
    wreg(ADDR_PART_ID, 8'ha5);
    rreg(ADDR_PART_ID, PART, "id kept");
    wreg(8'h07, 8'h11);
    rreg(8'h07, 8'h00, "unmapped");
    addr_sel <= 1'b1;
    u_host.wr(ADDR_LEFT_VOL, 8'h40, DEV_ADDR_BASE, ok);
    chk("old addr ack", ok, 1'b0);
    u_host.wr(ADDR_LEFT_VOL, 8'h41, DEV_ADDR_BASE | 7'h01, ok);
    chk("strap addr ack", ok, 1'b1);
    chk("gain_l", gain_l, 9'sh041 - 9'sd207);
    // a frozen block must neither answer nor store
    ce <= 1'b0;
    u_host.wr(ADDR_LEFT_VOL, 8'h22, DEV_ADDR_BASE | 7'h01, ok);
    chk("frozen ack", ok, 1'b0);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk("frozen gain_l", gain_l, 9'sh041 - 9'sd207);
    addr_sel <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(ADDR_LEFT_VOL, 8'hcf, "left after reset");
    $display("test misc done");
    complete_run();
  end
endmodule
`default_nettype wire
